// [cscg_pkg.sv]
// shared constants, register map and configuration types of the codec sample clock generator
// ----------------------------------------------------------------------------
// Operation
// - divider input from master or bit clock
// - integer divide ratio two through seventeen
// - codec clock from divider or divided pll output
// - fsref from codec clock; adc/dac factors
// - dual rate separately for adc and dac
// - pll reference from master or bit clock
// - pll set by input divider, multipliers
// ----------------------------------------------------------------------------
package cscg_pkg;

  localparam int          REG_AW          = 8;
  localparam int          REG_DW          = 32;

  // ----------------------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------------------
  localparam logic [7:0]  OFF_CTRL        = 8'h00;
  localparam logic [7:0]  OFF_INT_DIV     = 8'h04;
  localparam logic [7:0]  OFF_PLL_CFG     = 8'h08;
  localparam logic [7:0]  OFF_PLL_FRAC    = 8'h0C;
  localparam logic [7:0]  OFF_RATE        = 8'h10;
  localparam logic [7:0]  OFF_STATUS      = 8'h14;

  // ----------------------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------------------
  localparam int          CTRL_DIV_SRC    = 0;
  localparam int          CTRL_PLL_SRC    = 1;
  localparam int          CTRL_CODEC_SRC  = 2;
  localparam int          CTRL_ADC_DUAL   = 3;
  localparam int          CTRL_DAC_DUAL   = 4;
  localparam int          PLL_P_LSB       = 0;
  localparam int          PLL_J_LSB       = 8;
  localparam int          PLL_R_LSB       = 16;
  localparam int          RATE_DAC_LSB    = 4;

  // ----------------------------------------------------------------------------
  // reset values and limits
  // ----------------------------------------------------------------------------
  localparam logic [4:0]  Q_MIN           = 5'h02;
  localparam logic [4:0]  Q_MAX           = 5'h11;
  localparam logic [4:0]  Q_RESET         = 5'h02;
  localparam logic [2:0]  P_RESET         = 3'h1;
  localparam logic [5:0]  J_RESET         = 6'h08;
  localparam logic [3:0]  R_RESET         = 4'h1;
  localparam logic [13:0] D_RESET         = 14'h0000;
  localparam logic [13:0] D_MAX           = 14'h270F;
  localparam logic [3:0]  RATE_RESET      = 4'h0;
  // one pll output pulse costs this many credits; j.d scaled by it
  localparam logic [31:0] PLL_UNIT        = 32'h0000_2710;
  // post divider of the pll output and codec clock to fsref ratio
  localparam logic [8:0]  PLL_POST_DIV    = 9'h008;
  localparam logic [8:0]  FSREF_DIV       = 9'h100;
  localparam logic [8:0]  FSREF_DIV_DUAL  = 9'h080;

  typedef enum logic
  {
    CSCG_SRC_MCLK,
    CSCG_SRC_BCLK
  } cscg_pin_type;

  typedef struct packed
  {
    logic         dac_dual;
    logic         adc_dual;
    logic         codec_pll;
    cscg_pin_type pll_src;
    cscg_pin_type div_src;
  } cscg_ctrl_type;

  typedef struct packed
  {
    logic [3:0]   r_mult;
    logic [5:0]   j_mult;
    logic [2:0]   p_div;
  } cscg_pll_type;

endpackage

// [cscg_divider.sv]
// pulse divider: emits one output pulse for every ratio input pulses
`timescale 1ns/1ns
`default_nettype none
module cscg_divider
#(
  parameter int W = 9
)
(
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         sync_clr,
  input  wire logic         in_pulse,
  input  wire logic [W-1:0] ratio,
  output var  logic         out_pulse
);
  import cscg_pkg::*;

  logic [W-1:0] cnt_q;
  wire          last = (cnt_q >= ratio - W'(1));

  // a ratio of one passes every pulse; a ratio of zero divides by 2^W
  assign out_pulse = in_pulse & last;

  always_ff @(posedge clk)
  begin
    if (rst || sync_clr)
      cnt_q <= '0;
    else if (in_pulse)
      cnt_q <= last ? '0 : cnt_q + W'(1);
  end
endmodule
`default_nettype wire

// [cscg_glitchfree_mux.sv]
// glitch free selector between two clock enable streams
`timescale 1ns/1ns
`default_nettype none
module cscg_glitchfree_mux
(
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic sel,
  input  wire logic pulse_a,
  input  wire logic pulse_b,
  output var  logic out_pulse,
  output var  logic active_sel,
  output var  logic switching
);
  import cscg_pkg::*;

  typedef enum logic [1:0] {ST_RUN, ST_PARK, ST_ARM} cscg_mux_state_type;

  cscg_mux_state_type state_q;
  cscg_mux_state_type state_d;
  logic               cur_q;

  wire cur_pulse = cur_q ? pulse_b : pulse_a;
  wire new_pulse = cur_q ? pulse_a : pulse_b;

  // output is silent from the cycle after the request through the cycle after the first pulse of the new source
  assign out_pulse  = (state_q == ST_RUN) & cur_pulse;
  assign active_sel = cur_q;
  assign switching  = (state_q != ST_RUN);

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      ST_RUN:  if (sel != cur_q) state_d = ST_PARK;
      ST_PARK: if (new_pulse) state_d = ST_ARM;
      ST_ARM:  state_d = ST_RUN;
      default: state_d = ST_RUN;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state_q <= ST_RUN;
      cur_q   <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      if (state_q == ST_PARK && new_pulse)
        cur_q <= ~cur_q;
    end
  end
endmodule
`default_nettype wire

// [cscg_core.sv]
// codec sample clock generator: source selection, integer divider, pll model, rate dividers, registers
`timescale 1ns/1ns
`default_nettype none
module cscg_core
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        mclk_pin,
  input  wire logic        bclk_pin,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output var  logic [31:0] reg_rdata,
  output var  logic        int_divider_output,
  output var  logic        pll_output,
  output var  logic        pll_divided_output,
  output var  logic        codec_clk_en,
  output var  logic        fsref_en,
  output var  logic        adc_fs_en,
  output var  logic        dac_fs_en
);
  import cscg_pkg::*;

  // ----------------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------------
  cscg_ctrl_type ctrl_q;
  cscg_pll_type  pll_q;
  logic [4:0]    q_ratio_q;
  logic [13:0]   d_frac_q;
  logic [3:0]    adc_rate_factor_q;
  logic [3:0]    dac_rate_factor_q;
  logic [31:0]   rdata_q;
  logic [31:0]   rdata_d;

  wire hit_ctrl   = (reg_addr == OFF_CTRL);
  wire hit_intdiv = (reg_addr == OFF_INT_DIV);
  wire hit_pll    = (reg_addr == OFF_PLL_CFG);
  wire hit_frac   = (reg_addr == OFF_PLL_FRAC);
  wire hit_rate   = (reg_addr == OFF_RATE);
  wire hit_status = (reg_addr == OFF_STATUS);

  // out of range ratios are clamped so the divider never leaves 2..17
  wire [4:0]  q_wr      = reg_wdata[4:0];
  wire [4:0]  q_clamped = (q_wr < Q_MIN) ? Q_MIN : ((q_wr > Q_MAX) ? Q_MAX : q_wr);
  wire [13:0] d_wr      = reg_wdata[13:0];
  wire [13:0] d_clamped = (d_wr > D_MAX) ? D_MAX : d_wr;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      ctrl_q            <= '0;
      pll_q             <= '{r_mult: R_RESET, j_mult: J_RESET, p_div: P_RESET};
      q_ratio_q         <= Q_RESET;
      d_frac_q          <= D_RESET;
      adc_rate_factor_q <= RATE_RESET;
      dac_rate_factor_q <= RATE_RESET;
    end
    else if (reg_wr)
    begin
      if (hit_ctrl)
        ctrl_q <= cscg_ctrl_type'(reg_wdata[CTRL_DAC_DUAL:CTRL_DIV_SRC]);
      if (hit_intdiv)
        q_ratio_q <= q_clamped;
      if (hit_pll)
      begin
        pll_q.p_div  <= reg_wdata[PLL_P_LSB +: 3];
        pll_q.j_mult <= reg_wdata[PLL_J_LSB +: 6];
        pll_q.r_mult <= reg_wdata[PLL_R_LSB +: 4];
      end
      if (hit_frac)
        d_frac_q <= d_clamped;
      if (hit_rate)
      begin
        adc_rate_factor_q <= reg_wdata[3:0];
        dac_rate_factor_q <= reg_wdata[RATE_DAC_LSB +: 4];
      end
    end
  end

  // ----------------------------------------------------------------------------
  // pin edge detection
  // ----------------------------------------------------------------------------
  logic mclk_prev_q;
  logic bclk_prev_q;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      mclk_prev_q <= 1'b0;
      bclk_prev_q <= 1'b0;
    end
    else
    begin
      mclk_prev_q <= mclk_pin;
      bclk_prev_q <= bclk_pin;
    end
  end

  wire mclk_rise = mclk_pin & ~mclk_prev_q;
  wire bclk_rise = bclk_pin & ~bclk_prev_q;

  // ----------------------------------------------------------------------------
  // integer divider path
  // ----------------------------------------------------------------------------
  wire int_divider_input = (ctrl_q.div_src == CSCG_SRC_BCLK) ? bclk_rise : mclk_rise;
  wire int_div_pulse;

  cscg_divider #(.W(5)) u_int_div
  (
    .clk       (clk),
    .rst       (rst),
    .sync_clr  (reg_wr & hit_intdiv),
    .in_pulse  (int_divider_input),
    .ratio     (q_ratio_q),
    .out_pulse (int_div_pulse)
  );

  // ----------------------------------------------------------------------------
  // pll: reference over p, then credit based multiply by r * j.d
  // ----------------------------------------------------------------------------
  wire pll_reference_input = (ctrl_q.pll_src == CSCG_SRC_BCLK) ? bclk_rise : mclk_rise;
  wire pll_ref_div;
  // p of zero stands for eight
  wire [3:0] p_ratio = (pll_q.p_div == 3'h0) ? 4'h8 : {1'b0, pll_q.p_div};

  cscg_divider #(.W(4)) u_pll_pdiv
  (
    .clk       (clk),
    .rst       (rst),
    .sync_clr  (reg_wr & hit_pll),
    .in_pulse  (pll_reference_input),
    .ratio     (p_ratio),
    .out_pulse (pll_ref_div)
  );

  // credits per divided reference pulse: r * (j * 10000 + d)
  wire [31:0] k_scaled  = 32'(pll_q.j_mult) * PLL_UNIT + 32'(d_frac_q);
  wire [31:0] credit_in = k_scaled * 32'(pll_q.r_mult);
  logic [31:0] credit_q;
  // at most one output pulse per clock, so the synthesised rate saturates at clk
  wire        credit_ok = (credit_q >= PLL_UNIT);
  wire [31:0] credit_add = pll_ref_div ? credit_in : 32'h0000_0000;
  wire [31:0] credit_sub = credit_ok ? PLL_UNIT : 32'h0000_0000;

  always_ff @(posedge clk)
  begin
    if (rst || (reg_wr && (hit_pll || hit_frac)))
      credit_q <= '0;
    else
      credit_q <= credit_q + credit_add - credit_sub;
  end

  wire pll_out_pulse = credit_ok;
  wire pll_div_pulse;

  cscg_divider #(.W(9)) u_pll_post
  (
    .clk       (clk),
    .rst       (rst),
    .sync_clr  (1'b0),
    .in_pulse  (pll_out_pulse),
    .ratio     (PLL_POST_DIV),
    .out_pulse (pll_div_pulse)
  );

  // ----------------------------------------------------------------------------
  // codec clock selection
  // ----------------------------------------------------------------------------
  wire codec_pulse;
  wire codec_active;
  wire codec_switching;

  cscg_glitchfree_mux u_codec_mux
  (
    .clk        (clk),
    .rst        (rst),
    .sel        (ctrl_q.codec_pll),
    .pulse_a    (int_div_pulse),
    .pulse_b    (pll_div_pulse),
    .out_pulse  (codec_pulse),
    .active_sel (codec_active),
    .switching  (codec_switching)
  );

  // ----------------------------------------------------------------------------
  // sample rate derivation
  // ----------------------------------------------------------------------------
  wire fsref_pulse;
  wire adc_pulse;
  wire dac_pulse;
  wire adc_dual_pulse;
  wire dac_dual_pulse;
  wire adc_base;
  wire dac_base;
  wire [8:0] adc_fsref_div = ctrl_q.adc_dual ? FSREF_DIV_DUAL : FSREF_DIV;
  wire [8:0] dac_fsref_div = ctrl_q.dac_dual ? FSREF_DIV_DUAL : FSREF_DIV;

  cscg_divider #(.W(9)) u_fsref
  (
    .clk       (clk),
    .rst       (rst),
    .sync_clr  (1'b0),
    .in_pulse  (codec_pulse),
    .ratio     (FSREF_DIV),
    .out_pulse (fsref_pulse)
  );

  cscg_divider #(.W(9)) u_adc_ref
  (
    .clk       (clk),
    .rst       (rst),
    .sync_clr  (1'b0),
    .in_pulse  (codec_pulse),
    .ratio     (adc_fsref_div),
    .out_pulse (adc_dual_pulse)
  );

  cscg_divider #(.W(9)) u_dac_ref
  (
    .clk       (clk),
    .rst       (rst),
    .sync_clr  (1'b0),
    .in_pulse  (codec_pulse),
    .ratio     (dac_fsref_div),
    .out_pulse (dac_dual_pulse)
  );

  assign adc_base = adc_dual_pulse;
  assign dac_base = dac_dual_pulse;

  // factor code n divides the reference by n + 1
  cscg_divider #(.W(5)) u_adc_rate
  (
    .clk       (clk),
    .rst       (rst),
    .sync_clr  (reg_wr & hit_rate),
    .in_pulse  (adc_base),
    .ratio     ({1'b0, adc_rate_factor_q} + 5'h01),
    .out_pulse (adc_pulse)
  );

  cscg_divider #(.W(5)) u_dac_rate
  (
    .clk       (clk),
    .rst       (rst),
    .sync_clr  (reg_wr & hit_rate),
    .in_pulse  (dac_base),
    .ratio     ({1'b0, dac_rate_factor_q} + 5'h01),
    .out_pulse (dac_pulse)
  );

  // ----------------------------------------------------------------------------
  // outputs, registered
  // ----------------------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      int_divider_output <= 1'b0;
      pll_output         <= 1'b0;
      pll_divided_output <= 1'b0;
      codec_clk_en       <= 1'b0;
      fsref_en           <= 1'b0;
      adc_fs_en          <= 1'b0;
      dac_fs_en          <= 1'b0;
    end
    else
    begin
      int_divider_output <= int_div_pulse;
      pll_output         <= pll_out_pulse;
      pll_divided_output <= pll_div_pulse;
      codec_clk_en       <= codec_pulse;
      fsref_en           <= fsref_pulse;
      adc_fs_en          <= adc_pulse;
      dac_fs_en          <= dac_pulse;
    end
  end

  // ----------------------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------------------
  wire [31:0] rd_ctrl   = {27'h000_0000, ctrl_q};
  wire [31:0] rd_intdiv = {27'h000_0000, q_ratio_q};
  wire [31:0] rd_pll    = {12'h000, pll_q.r_mult, 2'b00, pll_q.j_mult, 5'h00, pll_q.p_div};
  wire [31:0] rd_frac   = {18'h0_0000, d_frac_q};
  wire [31:0] rd_rate   = {24'h00_0000, dac_rate_factor_q, adc_rate_factor_q};
  wire [31:0] rd_status = {30'h0000_0000, codec_switching, codec_active};

  always_comb
  begin
    rdata_d = 32'h0000_0000;
    if (reg_rd)
    begin
      if (hit_ctrl)   rdata_d = rd_ctrl;
      if (hit_intdiv) rdata_d = rd_intdiv;
      if (hit_pll)    rdata_d = rd_pll;
      if (hit_frac)   rdata_d = rd_frac;
      if (hit_rate)   rdata_d = rd_rate;
      if (hit_status) rdata_d = rd_status;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      rdata_q <= 32'h0000_0000;
    else
      rdata_q <= rdata_d;
  end

  assign reg_rdata = rdata_q;
endmodule
`default_nettype wire

// [cscg_core_asserts.sv]
// port level assertions for the codec sample clock generator core
`timescale 1ns/1ns
`default_nettype none
module cscg_core_asserts
(
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        mclk_pin,
  input wire logic        bclk_pin,
  input wire logic [7:0]  reg_addr,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic        int_divider_output,
  input wire logic        pll_output,
  input wire logic        pll_divided_output,
  input wire logic        codec_clk_en,
  input wire logic        fsref_en,
  input wire logic        adc_fs_en,
  input wire logic        dac_fs_en
);
  import cscg_pkg::*;
  logic        mclk_q;
  logic        bclk_q;
  logic [1:0]  edge_q;
  logic [1:0]  edges_q;
  logic [9:0]  fs_q;
  logic [3:0]  pll_q;
  logic [12:0] adc_q;
  logic [12:0] dac_q;
  // ----------------------------------------------------------------------------
  // helper counters
  // ----------------------------------------------------------------------------
  // any register write restarts the span counts, which can only lower them: no false alarms
  always_ff @(posedge clk)
  begin
    mclk_q <= mclk_pin;
    bclk_q <= bclk_pin;
    edge_q <= {edge_q[0], (mclk_pin & ~mclk_q) | (bclk_pin & ~bclk_q)};
    if (rst || int_divider_output || (reg_wr && reg_addr == OFF_INT_DIV))
      edges_q <= 2'h0;
    else if (edge_q[0] && edges_q != 2'h3)
      edges_q <= edges_q + 2'h1;
    fs_q  <= (rst || reg_wr || fsref_en) ? 10'h000 : fs_q + {9'h000, codec_clk_en};
    pll_q <= (rst || reg_wr || pll_divided_output) ? 4'h0 : pll_q + {3'h0, pll_output};
    adc_q <= (rst || reg_wr || adc_fs_en) ? 13'h0000 : adc_q + {12'h000, codec_clk_en};
    dac_q <= (rst || reg_wr || dac_fs_en) ? 13'h0000 : dac_q + {12'h000, codec_clk_en};
  end
  // ----------------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0000_0000)
    else $error("read data not zero while idle");
  a_unmapped_read: assert property (reg_rd && reg_addr > OFF_STATUS |=> reg_rdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  a_ratio_range: assert property (reg_rd && reg_addr == OFF_INT_DIV |=>
    reg_rdata[4:0] inside {[Q_MIN:Q_MAX]} && reg_rdata[31:5] == 27'h000_0000) else $error("divide ratio out of range");
  // edge_q[0] and the output pulse both trail the pin edge by one clock
  a_div_edges: assert property (int_divider_output |-> ({1'b0, edges_q} + {2'h0, edge_q[0]}) >= 3'h2)
    else $error("divider pulse after fewer than two edges");
  a_fsref_span: assert property (fs_q <= 10'h101)
    else $error("fsref gap over 256 codec pulses");
  a_plldiv_span: assert property (pll_q <= 4'h9)
    else $error("pll divided gap over 8 pll pulses");
  a_adc_span: assert property (adc_q <= 13'h1001)
    else $error("adc rate gap too long");
  a_dac_span: assert property (dac_q <= 13'h1001)
    else $error("dac rate gap too long");
  a_codec_single: assert property (codec_clk_en |=> !codec_clk_en [*3])
    else $error("codec clock pulses too close");
  c_fsref: cover property (fsref_en);
  c_pll_codec: cover property (pll_divided_output ##[1:2] codec_clk_en);
  c_dac: cover property (dac_fs_en);
endmodule
bind cscg_core cscg_core_asserts cscg_core_asserts_inst
(
  .clk(clk), .rst(rst), .mclk_pin(mclk_pin), .bclk_pin(bclk_pin), .reg_addr(reg_addr), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .int_divider_output(int_divider_output), .pll_output(pll_output),
  .pll_divided_output(pll_divided_output), .codec_clk_en(codec_clk_en), .fsref_en(fsref_en),
  .adc_fs_en(adc_fs_en), .dac_fs_en(dac_fs_en)
);
`default_nettype wire

// [cscg_clk_model.sv]
// board clock sources: master clock on pins[0], bit clock on pins[1]
`timescale 1ns/1ns
`default_nettype none
module cscg_clk_model
(
  input  wire logic            clk,
  input  wire logic [1:0][3:0] half,
  output var  logic [1:0]      pins
);
  logic [1:0][3:0] cnt_q;
  // ----------------------------------------------------------------------------
  // generators
  // ----------------------------------------------------------------------------
  // a zero half period parks that clock low, like a stopped source
  initial
  begin
    pins  = 2'h0;
    cnt_q = '0;
  end
  always @(posedge clk)
  begin
    for (int i = 0; i < 2; i++)
    begin
      if (half[i] == 4'h0)
      begin
        pins[i]  <= 1'b0;
        cnt_q[i] <= 4'h0;
      end
      else if (cnt_q[i] + 4'h1 >= half[i])
      begin
        pins[i]  <= ~pins[i];
        cnt_q[i] <= 4'h0;
      end
      else
        cnt_q[i] <= cnt_q[i] + 4'h1;
    end
  end
endmodule
`default_nettype wire

// [tb_codec_sample_clock_generator.sv]
// self-checking testbench of the codec sample clock generator core
`timescale 1ns/1ns
`default_nettype none
module tb_codec_sample_clock_generator;
  import cscg_pkg::*;
  logic            clk;
  logic            rst;
  logic [1:0][3:0] half;
  logic [1:0]      pins;
  logic [1:0]      pins_q;
  logic [7:0]      reg_addr;
  logic [31:0]     reg_wdata;
  logic            reg_wr;
  logic            reg_rd;
  logic [31:0]     reg_rdata;
  logic            int_divider_output, pll_output, pll_divided_output, codec_clk_en, fsref_en, adc_fs_en, dac_fs_en;
  int              bad_count = 0;
  int              checks_done = 0;
  int              qin [3] = '{0, 31, 5};
  int              qex [3] = '{2, 17, 5};
  // 0 mclk edge, 1 bclk edge, 2 divider, 3 pll, 4 pll divided, 5 codec, 6 fsref, 7 adc, 8 dac
  wire logic [8:0] ev = {dac_fs_en, adc_fs_en, fsref_en, codec_clk_en, pll_divided_output, pll_output,
                         int_divider_output, pins & ~pins_q};
  cscg_clk_model cscg_clk_model_inst (.clk(clk), .half(half), .pins(pins));
  cscg_core cscg_core_inst
  (
    .clk(clk), .rst(rst), .mclk_pin(pins[0]), .bclk_pin(pins[1]), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .int_divider_output(int_divider_output),
    .pll_output(pll_output), .pll_divided_output(pll_divided_output), .codec_clk_en(codec_clk_en),
    .fsref_en(fsref_en), .adc_fs_en(adc_fs_en), .dac_fs_en(dac_fs_en)
  );
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) pins_q <= pins;
  // ----------------------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------------------
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    @(negedge clk);
    chk($sformatf("register %h", a), reg_rdata, exp);
  endtask
  // counts src events over one full gap between two dst pulses
  task automatic ratio(input int src, input int dst, input int exp);
    int n;
    int t;
    n = 0;
    for (t = 0; t < 20000 && ev[dst] !== 1'b1; t++)
      @(negedge clk);
    if (t == 20000)
    begin
      bad_count++;
      $display("[FAIL] event %0d expected first pulse seen none", dst);
      summarize();
    end
    @(negedge clk);
    for (t = 0; t < 20000 && ev[dst] !== 1'b1; t++)
    begin
      n += int'(ev[src] === 1'b1);
      @(negedge clk);
    end
    n += int'(ev[src] === 1'b1);
    if (t == 20000)
    begin
      bad_count++;
      $display("[FAIL] event %0d expected pulse seen none", dst);
      summarize();
    end
    else
      chk($sformatf("events %0d per %0d", src, dst), 32'(n), 32'(exp));
  endtask
  // ----------------------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------------------
  initial
  begin
    rst       = 1'b1;
    half      = {4'h3, 4'h2};
    reg_addr  = 8'h00;
    reg_wdata = 32'h0000_0000;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    rd(OFF_CTRL, 32'h0000_0000);
    rd(OFF_INT_DIV, 32'h0000_0002);
    rd(OFF_PLL_CFG, 32'h0001_0801);
    rd(OFF_PLL_FRAC, 32'h0000_0000);
    rd(OFF_RATE, 32'h0000_0000);
    rd(OFF_STATUS, 32'h0000_0000);
    wr(8'h40, 32'hFFFF_FFFF);
    rd(8'h40, 32'h0000_0000);
    rd(OFF_CTRL, 32'h0000_0000);
    $display("test done: reset values");
    for (int s = 0; s < 2; s++)
      for (int i = 0; i < 3; i++)
      begin
        wr(OFF_CTRL, 32'(s));
        wr(OFF_INT_DIV, 32'(qin[i]));
        rd(OFF_INT_DIV, 32'(qex[i]));
        ratio(s, 2, qex[i]);
      end
    $display("test done: integer divider");
    wr(OFF_CTRL, 32'h0000_0000);
    wr(OFF_INT_DIV, 32'h0000_0002);
    ratio(2, 5, 1);
    ratio(5, 6, 256);
    wr(OFF_RATE, 32'h0000_0021);
    wr(OFF_CTRL, 32'h0000_0010);
    ratio(5, 7, 512);
    ratio(5, 8, 384);
    wr(OFF_CTRL, 32'h0000_0008);
    ratio(5, 7, 256);
    ratio(5, 8, 768);
    $display("test done: sample rates");
    wr(OFF_PLL_CFG, 32'h0002_0204);
    rd(OFF_PLL_CFG, 32'h0002_0204);
    wr(OFF_PLL_FRAC, 32'h0000_FFFF);
    rd(OFF_PLL_FRAC, 32'h0000_270F);
    wr(OFF_PLL_FRAC, 32'h0000_0000);
    wr(OFF_CTRL, 32'h0000_0004);
    ratio(3, 4, 8);
    ratio(0, 4, 8);
    ratio(4, 5, 1);
    wr(OFF_CTRL, 32'h0000_0006);
    ratio(1, 4, 8);
    rd(OFF_STATUS, 32'h0000_0001);
    wr(OFF_CTRL, 32'h0000_0000);
    ratio(2, 5, 1);
    rd(OFF_STATUS, 32'h0000_0000);
    $display("test done: pll path");
    summarize();
  end
endmodule
`default_nettype wire
